// file: slsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host end of the link: one timing event per call of send
module slsm_host_model (
   input  wire logic   clk,
   output logic        sync_pulse_o,   // timing signal level
   output logic        rx_ok_o,        // reception quality as the unit sees it
   output logic [15:0] rx_word_o       // first output word
);
   initial begin
      sync_pulse_o = 1'b0;
      rx_ok_o      = 1'b0;
      rx_word_o    = 16'h0000;
   end
   // word set up one edge ahead of the pulse, held through it
   task send(input logic [15:0] w, input logic ok);
      rx_word_o <= w;
      rx_ok_o   <= ok;
      @(posedge clk);
      sync_pulse_o <= 1'b1;
      repeat (4) @(posedge clk);
      // hold over: stale values would hide a late sample, so invert
      sync_pulse_o <= 1'b0;
      rx_word_o    <= ~w;
      rx_ok_o      <= ~ok;
      @(posedge clk);
   endtask : send
endmodule : slsm_host_model
`default_nettype wire

// file: slsm_pkg.sv
package slsm_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ            = 20_000_000;   // system clock rate
   localparam int unsigned UNIT_CYCLE_US     = 500;          // internal control cycle
   localparam int unsigned UNIT_CYCLE_CLKS   = (UNIT_CYCLE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned TIMEOUT_TICKS     = 4;            // unit cycles without timing signal
   localparam int unsigned RX_FAIL_LIMIT     = 2;            // consecutive failed receptions
   localparam int unsigned PERIOD_W          = 20;           // holds a 10 ms period at 20 MHz

   // register byte offsets
   localparam logic [3:0] REG_MASK_OFS       = 4'h0;
   localparam logic [3:0] REG_STATUS_OFS     = 4'h4;
   localparam logic [3:0] REG_CTRL_OFS       = 4'h8;
   localparam logic [3:0] REG_PERIOD_OFS     = 4'hc;

   // reset values
   localparam logic [15:0] MASK_RESET        = 16'h0000;
   localparam logic [15:0] MASK_WRITABLE     = 16'h7fff;     // bit 15 reserved, reads zero

   // status bit positions
   localparam int unsigned ST_TIMEOUT        = 0;
   localparam int unsigned ST_RX_ERR         = 1;
   localparam int unsigned ST_RX_WARN        = 2;
   localparam int unsigned ST_CYC_ERR        = 3;
   localparam int unsigned ST_SYNC_ACT       = 4;
   localparam int unsigned ST_STOP_ACT       = 5;

   // control bit positions (write one to act)
   localparam int unsigned CT_ERR_RESET      = 0;
   localparam int unsigned CT_WARN_CLR       = 1;

   // received word layout
   localparam int unsigned ALL_STOP_BIT      = 15;
   localparam int unsigned GROUP_BITS        = 15;
endpackage : slsm_pkg

// file: slsm_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module slsm_tick_gen #(
   parameter int unsigned DIV = 10000             // clocks per tick
) (
   input  wire logic clk,
   input  wire logic rst_b,
   output logic      tick
);
   localparam int unsigned CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;                          // free running divider
   logic [CW-1:0] cnt_d;
   logic          tick_q;

   assign cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);

   // divider and one-cycle enable pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= (cnt_q == LAST);
      end
   end

   assign tick = tick_q;
endmodule : slsm_tick_gen
`default_nettype wire

// file: slsm_top.sv
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slsm_top
   import slsm_pkg::*;
#(
   parameter int unsigned UNIT_CYC_CLKS = UNIT_CYCLE_CLKS  // internal control cycle in clocks
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   // host link side
   input  wire logic        sync_pulse_i,     // timing signal level, high while signalled
   input  wire logic        rx_ok_i,          // reception good, valid with timing signal
   input  wire logic [15:0] rx_word_i,        // first output word of the link area
   // unit side
   output logic             func_stop_o,      // one-cycle stop command
   output logic             func_abort_o,     // one-cycle abort of ongoing process
   output logic             sync_active_o,    // unit in synchronous control
   output logic [15:0]      link_word_o,      // last good first word
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   // pin synchronisers, first stage read only by second
   logic [17:0] s1_q;
   logic [17:0] s2_q;
   logic        pulse_d1_q;                   // previous sync level for edge detect
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q       <= '0;
         s2_q       <= '0;
         pulse_d1_q <= 1'b0;
      end else begin
         s1_q       <= {sync_pulse_i, rx_ok_i, rx_word_i};
         s2_q       <= s1_q;
         pulse_d1_q <= s2_q[17];
      end
   end

   wire        sync_ev  = s2_q[17] & ~pulse_d1_q;   // one event per timing signal
   wire        rx_good  = s2_q[16];
   wire [15:0] rx_word  = s2_q[15:0];

   // unit control cycle enable
   logic unit_tick;
   slsm_tick_gen #(.DIV(UNIT_CYC_CLKS)) u_tick (
      .clk   (clk),
      .rst_b (rst_b),
      .tick  (unit_tick)
   );

   // state
   logic [15:0]         mask_q;               // group stop selection
   logic [15:0]         word_q;               // held link word
   logic                seen_q;               // a timing signal has arrived
   logic                timeout_q;
   logic                rx_err_q;
   logic                rx_warn_q;
   logic                cyc_err_q;
   logic [1:0]          fail_cnt_q;           // consecutive failed receptions
   logic [2:0]          silent_q;             // unit ticks since last timing signal
   logic [PERIOD_W-1:0] per_cnt_q;            // clocks since last timing signal
   logic [PERIOD_W-1:0] period_q;             // last measured sync cycle
   logic [15:0]         req_prev_q;           // previous accepted request bits
   logic                stop_q;
   logic                abort_q;

   // bus decode
   wire acc      = avs_read | avs_write;
   logic ack_q;
   wire wr_hit   = avs_write & ack_q;
   wire wr_mask  = wr_hit & (avs_address == REG_MASK_OFS);
   wire wr_ctrl  = wr_hit & (avs_address == REG_CTRL_OFS);
   wire err_rst  = wr_ctrl & avs_byteenable[0] & avs_writedata[CT_ERR_RESET];
   wire warn_clr = wr_ctrl & avs_byteenable[0] & avs_writedata[CT_WARN_CLR];

   // stopped for good: only restart leaves this
   wire dead      = timeout_q | cyc_err_q;
   wire sync_act  = seen_q & ~dead;
   wire good_rx   = sync_ev & rx_good & sync_act;
   wire bad_rx    = sync_ev & ~rx_good & sync_act;
   wire rx_limit  = bad_rx & (fail_cnt_q == 2'(RX_FAIL_LIMIT - 1));
   wire to_hit    = sync_act & unit_tick & ~sync_ev &
                    (silent_q == 3'(TIMEOUT_TICKS - 1));
   // counter holds clocks minus one at the event, so add the event clock back
   wire [PERIOD_W-1:0] per_meas = (per_cnt_q == {PERIOD_W{1'b1}}) ? per_cnt_q :
                                  per_cnt_q + PERIOD_W'(1);
   wire cyc_hit   = sync_ev & seen_q & ~dead &
                    (per_meas < PERIOD_W'(UNIT_CYC_CLKS));

   // request decode on the word that is being acted on
   wire [15:0] req_now  = good_rx ? rx_word : word_q;
   wire [15:0] req_rise = req_now & ~req_prev_q;
   wire grp_stop  = |(req_rise[GROUP_BITS-1:0] & mask_q[GROUP_BITS-1:0]);
   wire all_stop  = req_rise[ALL_STOP_BIT];
   wire stop_d    = sync_act & (grp_stop | all_stop);
   wire abort_d   = to_hit | cyc_hit | (rx_limit & ~rx_err_q);

   // link timing monitor
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_q     <= 1'b0;
         silent_q   <= '0;
         per_cnt_q  <= '0;
         period_q   <= '0;
      end else begin
         if (sync_ev) begin
            seen_q    <= 1'b1;
            silent_q  <= '0;
            per_cnt_q <= '0;
            period_q  <= per_meas;                                    // equal periods are legal
         end else begin
            if (unit_tick && silent_q != 3'(TIMEOUT_TICKS)) begin
               silent_q <= silent_q + 3'd1;
            end
            if (per_cnt_q != {PERIOD_W{1'b1}}) begin
               per_cnt_q <= per_cnt_q + PERIOD_W'(1);                 // saturates, never wraps
            end
         end
      end
   end

   // error flags; the hardware set wins over software clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timeout_q  <= 1'b0;
         cyc_err_q  <= 1'b0;
         rx_err_q   <= 1'b0;
         rx_warn_q  <= 1'b0;
         fail_cnt_q <= '0;
      end else begin
         if (to_hit) timeout_q <= 1'b1;
         if (cyc_hit) cyc_err_q <= 1'b1;
         if (rx_limit) rx_err_q <= 1'b1;
         else if (err_rst) rx_err_q <= 1'b0;
         if (bad_rx) rx_warn_q <= 1'b1;
         else if (warn_clr) rx_warn_q <= 1'b0;
         if (good_rx) fail_cnt_q <= '0;
         else if (bad_rx && fail_cnt_q != 2'(RX_FAIL_LIMIT)) fail_cnt_q <= fail_cnt_q + 2'd1;
      end
   end

   // data hold and stop generation
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         word_q     <= '0;
         req_prev_q <= '0;
         stop_q     <= 1'b0;
         abort_q    <= 1'b0;
      end else begin
         if (good_rx) word_q <= rx_word;
         req_prev_q <= req_now;
         stop_q     <= stop_d;
         abort_q    <= abort_d;
      end
   end

   // register file
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= MASK_RESET;
      end else begin
         if (wr_mask && avs_byteenable[0]) mask_q[7:0]  <= avs_writedata[7:0];
         if (wr_mask && avs_byteenable[1]) mask_q[15:8] <= avs_writedata[15:8] & MASK_WRITABLE[15:8];
      end
   end

   // status word, one bit per condition
   wire [31:0] status_w = {26'h000_0000, stop_q, sync_act, cyc_err_q,
                           rx_warn_q, rx_err_q, timeout_q};
   wire [31:0] rd_mux   = (avs_address == REG_MASK_OFS)   ? {16'h0000, mask_q} :
                          (avs_address == REG_STATUS_OFS) ? status_w :
                          (avs_address == REG_PERIOD_OFS) ? {12'h000, period_q} :
                          32'h0000_0000;                              // ctrl and unmapped read zero

   // one wait cycle per access, answer on the second edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q        <= 1'b0;
         avs_readdata <= '0;
      end else begin
         ack_q <= acc & ~ack_q;
         if (avs_read && !ack_q) avs_readdata <= rd_mux;
      end
   end

   assign avs_waitrequest = acc & ~ack_q;
   assign func_stop_o     = stop_q;
   assign func_abort_o    = abort_q;
   assign sync_active_o   = sync_act;
   assign link_word_o     = word_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // second failure in a row while the error is still clear
   sequence two_bad_s;
      bad_rx && (fail_cnt_q == 2'(RX_FAIL_LIMIT - 1)) && !rx_err_q;
   endsequence

   stop_masked_a: assert property ((!mask_q[0] && !all_stop && !grp_stop) |=> !stop_q)
      else $error("stop without enabled request");
   stop_group_a: assert property ((sync_act && req_rise[0] && mask_q[0]) |=> stop_q)
      else $error("enabled group stop missed");
   stop_all_a: assert property ((sync_act && req_rise[ALL_STOP_BIT]) |=> stop_q)
      else $error("all stop missed");
   timeout_set_a: assert property (to_hit |=> timeout_q && !sync_active_o)
      else $error("timeout not raised");
   timeout_hold_a: assert property (timeout_q |=> timeout_q && !sync_active_o)
      else $error("timeout left before restart");
   rx_err_set_a: assert property (two_bad_s |=> rx_err_q && abort_q)
      else $error("reception error not raised");
   rx_err_clr_a: assert property ((rx_err_q && err_rst && !rx_limit) |=> !rx_err_q)
      else $error("error reset ignored");
   rx_warn_a: assert property (bad_rx |=> rx_warn_q && $stable(word_q))
      else $error("warning or data hold wrong");
   cyc_err_a: assert property (cyc_hit |=> cyc_err_q ##1 cyc_err_q)
      else $error("cycle error not held");
   bus_wait_a: assert property ((acc && !ack_q) |=> (!avs_waitrequest || !acc))
      else $error("bus answer late");
endmodule : slsm_top
`default_nettype wire

// file: tb_sync_link_stop_and_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_link_stop_and_monitor;
   import slsm_pkg::*;
   localparam int unsigned UC = 20;  // short unit cycle keeps the run brief
   logic        clk, rst_b, sp, ok, stop, abrt, act, rd, wr, wq;
   logic [15:0] rw, lw, prev, good, mask;  // prev/good/mask: bench model state
   logic [3:0]  adr, be;
   logic [31:0] wd, rdat, q;
   int          n_mismatch = 0, num_checks = 0, seed = 32'h73f9, n_stop = 0, n_abort = 0, a0;
   bit          live;  // model: first event seen

   slsm_top #(.UNIT_CYC_CLKS(UC)) DUT (.clk(clk), .rst_b(rst_b), .sync_pulse_i(sp), .rx_ok_i(ok),
      .rx_word_i(rw), .func_stop_o(stop), .func_abort_o(abrt), .sync_active_o(act), .link_word_o(lw),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wq));
   slsm_host_model HOST (.clk(clk), .sync_pulse_o(sp), .rx_ok_o(ok), .rx_word_o(rw));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulse counters for the one-cycle outputs
   always @(posedge clk) begin
      if (stop === 1'b1) n_stop++;
      if (abrt === 1'b1) n_abort++;
   end
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // one avalon transfer, held until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= !w;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      r = rdat;  // taken at the edge that sees waitrequest low
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus
   task st(input logic [31:0] e);
      bus(1'b0, REG_STATUS_OFS, 32'h0000_0000, q);
      chk("status", q & 32'h0000_001f, e);
   endtask : st
   task restart;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      prev = 16'h0000;
      good = 16'h0000;
      mask = 16'h0000;
      live = 1'b0;
   endtask : restart
   // one timing event; bench model predicts stop pulse and kept word
   task ev(input logic [15:0] w, input logic k, input int gap);
      int   s0;
      logic e;
      s0 = n_stop;
      HOST.send(w, k);
      repeat (gap) @(posedge clk);
      e = 1'b0;
      if (k && live) begin
         e = ((w & ~prev & {1'b1, mask[14:0]}) != 16'h0000);
         prev = w;
         good = w;
      end
      live = 1'b1;
      chk("stop count", 32'(n_stop - s0), {31'h0, e});
      chk("link word", {16'h0000, lw}, {16'h0000, good});
   endtask : ev
   task conclude;
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      rst_b = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      wd = 32'h0000_0000;
      be = 4'hf;
      restart();
      bus(1'b0, REG_MASK_OFS, 32'h0000_0000, q);
      chk("mask reset", q, 32'h0000_0000);
      bus(1'b0, REG_CTRL_OFS, 32'h0000_0000, q);
      chk("ctrl read", q, 32'h0000_0000);
      ev(16'h0000, 1'b1, 24);
      ev(16'h7fff, 1'b1, 24);
      // host send spans 6 clocks, plus the 24 clock gap
      bus(1'b0, REG_PERIOD_OFS, 32'h0000_0000, q);
      chk("period", q, 32'h0000_001e);
      for (int i = 0; i < 12; i++) begin
         if (i % 4 == 0) begin
            mask = 16'($random(seed));
            bus(1'b1, REG_MASK_OFS, {16'h0000, mask}, q);
            bus(1'b0, REG_MASK_OFS, 32'h0000_0000, q);
            chk("mask", q, {17'h0, mask[14:0]});
         end
         ev(16'($random(seed)), 1'b1, 24);
      end
      // low lane only: the upper mask byte keeps its value
      be <= 4'h1;
      bus(1'b1, REG_MASK_OFS, 32'h0000_7fff, q);
      be <= 4'hf;
      mask[7:0] = 8'hff;
      bus(1'b0, REG_MASK_OFS, 32'h0000_0000, q);
      chk("mask lane", q, {17'h0, mask[14:0]});
      // one bad reception, then a second in a row
      ev(~good, 1'b0, 24);
      st(32'h0000_0014);
      a0 = n_abort;
      ev(~good, 1'b0, 24);
      st(32'h0000_0016);
      chk("abort rx", 32'(n_abort - a0), 32'h0000_0001);
      bus(1'b1, REG_STATUS_OFS, 32'hffff_ffff, q);
      bus(1'b1, REG_CTRL_OFS, 32'h0000_0003, q);
      st(32'h0000_0010);
      chk("sync active", {31'h0, act}, 32'h0000_0001);
      // host falls silent
      a0 = n_abort;
      repeat (100) @(posedge clk);
      st(32'h0000_0001);
      chk("abort to", 32'(n_abort - a0), 32'h0000_0001);
      HOST.send(16'h0000, 1'b1);
      repeat (24) @(posedge clk);
      st(32'h0000_0001);
      chk("sync active", {31'h0, act}, 32'h0000_0000);
      restart();
      st(32'h0000_0000);
      // host period shorter than the unit cycle
      ev(16'h0000, 1'b1, 2);
      a0 = n_abort;
      ev(16'h0000, 1'b1, 24);
      st(32'h0000_0008);
      chk("abort cyc", 32'(n_abort - a0), 32'h0000_0001);
      restart();
      st(32'h0000_0000);
      conclude();
   end
endmodule : tb_sync_link_stop_and_monitor
`default_nettype wire
